// >>> include/breaker_defs.svh
// Constants for the breaker command control block
`ifndef BREAKER_DEFS_SVH
`define BREAKER_DEFS_SVH
// ==========================================
// Time base
`define BCC_CLK_PERIOD_NS 4
`define BCC_MS_NS 1000000
// ==========================================
// Times in milliseconds
`define BCC_OPER_MS 16'd150
`define BCC_MIN_PULSE_MS 16'd100
`define BCC_PULSE_MS_RST 16'd300
`define BCC_SYNC_WAIT_RST 16'd1000
`define BCC_SYNSW_RST 16'd0
`define BCC_INTER_MS_RST 16'd100
// ==========================================
// Register byte offsets
`define BCC_REG_CMD 8'h00
`define BCC_REG_PULSE 8'h04
`define BCC_REG_SYNC 8'h08
`define BCC_REG_SYNSW 8'h0c
`define BCC_REG_INTER 8'h10
`define BCC_REG_STATUS 8'h14
`define BCC_REG_COUNT 8'h18
`define BCC_REG_CLEAR 8'h1c
// ==========================================
// Fields
`define BCC_CMD_CLOSE_BIT 0
`define BCC_CMD_REMOTE_BIT 1
`define BCC_CLR_COUNT_BIT 0
`define BCC_CLR_UNINT_BIT 1
`define BCC_RESP_OKAY 2'b00
`define BCC_RESP_SLVERR 2'b10
`endif

// >>> include/breaker_pkg.sv
// Types for the breaker command control block
package breaker_pkg;
    // Breaker position code: 0 intermediate, 1 open, 2 closed, 3 faulty
    typedef enum logic [1:0] {CB_INTER, CB_OPEN, CB_CLOSED, CB_FAULTY} cb_state_e;
    typedef enum logic [2:0] {S_IDLE, S_SYNC, S_SWAIT, S_OPEN, S_CLOSE} ctl_state_e;
endpackage

// >>> rtl/ms_tick_gen.sv
// Millisecond enable pulse from the system clock
`timescale 1ns/1ps
`default_nettype none
module ms_tick_gen #(
    parameter int unsigned DIV = 250000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // One-cycle enable every DIV cycles
    output logic tick
);
    logic [31:0] cnt_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= 32'h0000_0000;
            tick <= 1'b0;
        end else if (cnt_q == 32'(DIV - 1)) begin
            cnt_q <= 32'h0000_0000;
            tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
            tick <= 1'b0;
        end
    end
endmodule // ms_tick_gen
`default_nettype wire

// >>> rtl/breaker_command_control.sv
// Breaker command control with AXI4-Lite register access
// ==========================================
// Notes on behaviour
// RULE_01: Local panel commands are taken only while the local enable is high.
// RULE_02: Remote or web commands are taken only while the remote enable is high.
// RULE_03: A close pulse is issued only while the synchronism permit is high.
// RULE_04: Without a synchro source the system ties the synchronism permit high.
// RULE_05: An open command runs only while the open interlock permit is high.
// RULE_06: A close command runs only while the close interlock permit is high.
// RULE_07: While the block input is high the breaker is never operated.
// RULE_08: The breaker drives open status and closed status inputs truly.
// RULE_09: External switching input only matters for the unintended operation decision.
// RULE_10: An accepted open request gives one open pulse of the set length.
// RULE_11: An accepted close request gives one close pulse of the set length.
// RULE_12: Synchronism missing for the wait limit during close fires the synchro trigger.
// RULE_13: Every breaker operation gives a 150 ms operation pulse.
// RULE_14: Status change without command or external switching sets unintended flag.
// RULE_15: A filtered closed output follows the closed status input.
// RULE_16: A filtered open output follows the open status input.
// RULE_17: The operation counter counts each rise of the operation pulse.
// RULE_18: Software can clear the operation counter to zero.
// RULE_19: Each change of derived breaker state emits an event with the state.
// RULE_20: One operation command selects open or close by its value.
// RULE_21: Confirmed switching ends the pulse early, never before 100 ms.
// RULE_22: State codes: 0 intermediate, 1 open, 2 closed, 3 faulty.
// RULE_23: A zero synchro-switch wait setting never fires the synchro trigger.
// RULE_24: Refused requests are dropped, never queued.
`timescale 1ns/1ps
`default_nettype none
`include "breaker_defs.svh"
module breaker_command_control import breaker_pkg::*; #(
    parameter int unsigned TICK_CYCLES = `BCC_MS_NS / `BCC_CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Place enables, permits and block
    input wire logic local_enable,
    input wire logic remote_enable,
    input wire logic synchronism_permit,
    input wire logic open_interlock_permit,
    input wire logic close_interlock_permit,
    input wire logic operation_block,
    // Breaker status
    input wire logic breaker_open_status,
    input wire logic breaker_closed_status,
    input wire logic external_switching_indication,
    // Breaker commands and indications
    output logic open_command_pulse,
    output logic close_command_pulse,
    output logic synchro_switch_trigger,
    output logic operation_pulse,
    output logic unintended_switching_flag,
    output logic breaker_closed,
    output logic breaker_opened,
    // State events
    output logic status_event_valid,
    output cb_state_e status_event_state
);
    // ==========================================
    // Time base
    logic ms_tick;

    ms_tick_gen #(.DIV(TICK_CYCLES)) u_tick (
        .clk(clk),
        .rst(rst),
        .tick(ms_tick)
    );

    // ==========================================
    // Register bus
    logic aw_got_q, w_got_q, bvalid_q, rvalid_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic do_wr, wr_hit, rd_hit;
    logic [15:0] pulse_ms_q, sync_wait_q, synsw_ms_q, inter_ms_q;
    logic [31:0] op_count_q;
    logic cmd_req, cmd_close, cmd_remote, clr_count, clr_unint;

    function automatic logic [15:0] merge16(input logic [15:0] q, input logic [31:0] d, input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : q[15:8], s[0] ? d[7:0] : q[7:0]};
    endfunction

    assign s_axi_awready = !aw_got_q;
    assign s_axi_wready = !w_got_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign do_wr = aw_got_q && w_got_q && !bvalid_q;

    always_comb begin
        unique case (awaddr_q)
            `BCC_REG_CMD, `BCC_REG_PULSE, `BCC_REG_SYNC, `BCC_REG_SYNSW,
            `BCC_REG_INTER, `BCC_REG_STATUS, `BCC_REG_COUNT, `BCC_REG_CLEAR: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // Address and data may arrive in either order
    always_ff @(posedge clk) begin
        if (rst) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= `BCC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_got_q) begin
                aw_got_q <= 1'b1;
                awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && !w_got_q) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? `BCC_RESP_OKAY : `BCC_RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    assign cmd_req = do_wr && awaddr_q == `BCC_REG_CMD && wstrb_q[0];
    assign cmd_close = wdata_q[`BCC_CMD_CLOSE_BIT]; // RULE_20
    assign cmd_remote = wdata_q[`BCC_CMD_REMOTE_BIT];
    assign clr_count = do_wr && awaddr_q == `BCC_REG_CLEAR && wstrb_q[0] && wdata_q[`BCC_CLR_COUNT_BIT];
    assign clr_unint = do_wr && awaddr_q == `BCC_REG_CLEAR && wstrb_q[0] && wdata_q[`BCC_CLR_UNINT_BIT];

    always_ff @(posedge clk) begin
        if (rst) begin
            pulse_ms_q <= `BCC_PULSE_MS_RST;
            sync_wait_q <= `BCC_SYNC_WAIT_RST;
            synsw_ms_q <= `BCC_SYNSW_RST;
            inter_ms_q <= `BCC_INTER_MS_RST;
        end else if (do_wr) begin
            unique case (awaddr_q)
                `BCC_REG_PULSE: pulse_ms_q <= merge16(pulse_ms_q, wdata_q, wstrb_q);
                `BCC_REG_SYNC: sync_wait_q <= merge16(sync_wait_q, wdata_q, wstrb_q);
                `BCC_REG_SYNSW: synsw_ms_q <= merge16(synsw_ms_q, wdata_q, wstrb_q);
                `BCC_REG_INTER: inter_ms_q <= merge16(inter_ms_q, wdata_q, wstrb_q);
                default: ;
            endcase
        end
    end

    // ==========================================
    // Position filter and events
    cb_state_e raw_state, state_q, last_pos_q;
    logic [15:0] inter_cnt_q;
    logic oper_start;
    logic [15:0] oper_cnt_q;

    // Encoding follows the two status inputs directly
    assign raw_state = cb_state_e'({breaker_closed_status, breaker_open_status}); // RULE_22

    // Intermediate shows only once it outlasts the travel time
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= CB_INTER;
            inter_cnt_q <= 16'h0000;
        end else if (raw_state != CB_INTER) begin
            state_q <= raw_state;
            inter_cnt_q <= 16'h0000;
        end else if (inter_cnt_q >= inter_ms_q) begin
            state_q <= CB_INTER;
        end else if (ms_tick) begin
            inter_cnt_q <= inter_cnt_q + 16'h0001;
        end
    end

    assign breaker_opened = state_q == CB_OPEN; // RULE_16
    assign breaker_closed = state_q == CB_CLOSED; // RULE_15

    always_ff @(posedge clk) begin
        if (rst) begin
            status_event_valid <= 1'b0;
            status_event_state <= CB_INTER;
        end else begin
            status_event_valid <= raw_state != state_q && (raw_state != CB_INTER || inter_cnt_q >= inter_ms_q); // RULE_19
            status_event_state <= (raw_state != CB_INTER) ? raw_state : CB_INTER;
        end
    end

    // Operation: a new definite position differing from the last one
    assign oper_start = (raw_state == CB_OPEN || raw_state == CB_CLOSED) && raw_state != state_q
        && last_pos_q != CB_INTER && raw_state != last_pos_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            last_pos_q <= CB_INTER;
        end else if (raw_state == CB_OPEN || raw_state == CB_CLOSED) begin
            last_pos_q <= raw_state;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            operation_pulse <= 1'b0;
            oper_cnt_q <= 16'h0000;
        end else if (oper_start) begin
            operation_pulse <= 1'b1; // RULE_13
            oper_cnt_q <= 16'h0000;
        end else if (operation_pulse && oper_cnt_q >= `BCC_OPER_MS) begin
            operation_pulse <= 1'b0;
        end else if (operation_pulse && ms_tick) begin
            oper_cnt_q <= oper_cnt_q + 16'h0001;
        end
    end

    // A clear in the same cycle as a count leaves the counter at one
    always_ff @(posedge clk) begin
        if (rst) begin
            op_count_q <= 32'h0000_0000;
        end else if (oper_start && !operation_pulse) begin
            op_count_q <= clr_count ? 32'h0000_0001 : op_count_q + 32'h0000_0001; // RULE_17
        end else if (clr_count) begin
            op_count_q <= 32'h0000_0000; // RULE_18
        end
    end

    // ==========================================
    // Command sequencer
    ctl_state_e ctl_q;
    logic [15:0] ms_cnt_q, cmd_hold_q;
    logic src_ok, pulse_done;

    assign src_ok = cmd_remote ? remote_enable : local_enable; // RULE_01 RULE_02
    assign open_command_pulse = ctl_q == S_OPEN; // RULE_10
    assign close_command_pulse = ctl_q == S_CLOSE; // RULE_11
    assign pulse_done = ms_cnt_q >= pulse_ms_q || (ms_cnt_q >= `BCC_MIN_PULSE_MS
        && state_q == (ctl_q == S_OPEN ? CB_OPEN : CB_CLOSED)); // RULE_21

    // Requests not taken at once are lost, there is no queue
    always_ff @(posedge clk) begin
        if (rst) begin
            ctl_q <= S_IDLE;
            synchro_switch_trigger <= 1'b0;
        end else begin
            synchro_switch_trigger <= 1'b0;
            unique case (ctl_q)
                S_IDLE: begin
                    if (cmd_req && src_ok && !operation_block) begin // RULE_24 RULE_07
                        if (!cmd_close && open_interlock_permit) begin // RULE_05
                            ctl_q <= S_OPEN;
                        end else if (cmd_close && close_interlock_permit) begin // RULE_06
                            ctl_q <= synchronism_permit ? S_CLOSE : S_SYNC; // RULE_03
                        end
                    end
                end
                S_SYNC, S_SWAIT: begin
                    if (operation_block || !close_interlock_permit) begin
                        ctl_q <= S_IDLE;
                    end else if (synchronism_permit) begin
                        ctl_q <= S_CLOSE;
                    end else if (ctl_q == S_SYNC && ms_cnt_q >= sync_wait_q) begin
                        synchro_switch_trigger <= synsw_ms_q != 16'h0000; // RULE_12 RULE_23
                        ctl_q <= synsw_ms_q != 16'h0000 ? S_SWAIT : S_IDLE;
                    end else if (ctl_q == S_SWAIT && ms_cnt_q >= synsw_ms_q) begin
                        ctl_q <= S_IDLE;
                    end
                end
                S_OPEN, S_CLOSE: begin
                    if (operation_block || pulse_done) begin // RULE_07
                        ctl_q <= S_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ms_cnt_q <= 16'h0000;
        end else if (ctl_q == S_IDLE || (ctl_q == S_SYNC && ms_cnt_q >= sync_wait_q)
            || (ctl_q inside {S_SYNC, S_SWAIT} && synchronism_permit)) begin
            ms_cnt_q <= 16'h0000;
        end else if (ms_tick && ms_cnt_q != 16'hffff) begin
            ms_cnt_q <= ms_cnt_q + 16'h0001;
        end
    end

    // A change within the travel time after our own pulse counts as commanded
    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_hold_q <= 16'h0000;
        end else if (open_command_pulse || close_command_pulse) begin
            cmd_hold_q <= inter_ms_q;
        end else if (ms_tick && cmd_hold_q != 16'h0000) begin
            cmd_hold_q <= cmd_hold_q - 16'h0001;
        end
    end

    // Set wins over a software clear
    always_ff @(posedge clk) begin
        if (rst) begin
            unintended_switching_flag <= 1'b0;
        end else if (oper_start && !open_command_pulse && !close_command_pulse
            && cmd_hold_q == 16'h0000 && !external_switching_indication) begin // RULE_14 RULE_09
            unintended_switching_flag <= 1'b1;
        end else if (clr_unint) begin
            unintended_switching_flag <= 1'b0;
        end
    end

    // ==========================================
    // Register read
    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `BCC_RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rresp_q <= `BCC_RESP_OKAY;
            unique case ({s_axi_araddr[7:2], 2'b00})
                `BCC_REG_PULSE: rdata_q <= {16'h0000, pulse_ms_q};
                `BCC_REG_SYNC: rdata_q <= {16'h0000, sync_wait_q};
                `BCC_REG_SYNSW: rdata_q <= {16'h0000, synsw_ms_q};
                `BCC_REG_INTER: rdata_q <= {16'h0000, inter_ms_q};
                `BCC_REG_STATUS: rdata_q <= {21'h000000, ctl_q, breaker_closed, breaker_opened,
                    unintended_switching_flag, operation_pulse, close_command_pulse,
                    open_command_pulse, state_q};
                `BCC_REG_COUNT: rdata_q <= op_count_q;
                `BCC_REG_CMD, `BCC_REG_CLEAR: rdata_q <= 32'h0000_0000;
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= `BCC_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ==========================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_open_gated: assert property ($rose(open_command_pulse) |-> // RULE_05
        $past(open_interlock_permit) && !$past(operation_block) && $past(cmd_req))
        else $error("open pulse without permit");
    a_close_gated: assert property ($rose(close_command_pulse) |-> // RULE_03
        $past(synchronism_permit) && $past(close_interlock_permit) && !$past(operation_block))
        else $error("close pulse without permits");
    a_block_stops: assert property (operation_block |=> !$rose(open_command_pulse) // RULE_07
        && !$rose(close_command_pulse)) else $error("pulse started while blocked");
    a_place_enable: assert property (cmd_req && !src_ok && ctl_q == S_IDLE |=> ctl_q == S_IDLE) // RULE_01
        else $error("command taken without place enable");
    a_pulse_min: assert property ($fell(open_command_pulse) || $fell(close_command_pulse) // RULE_21
        |-> $past(operation_block) || $past(ms_cnt_q) >= `BCC_MIN_PULSE_MS)
        else $error("pulse shorter than minimum");
    a_pulse_max: assert property ((open_command_pulse || close_command_pulse) // RULE_10
        |-> ms_cnt_q <= pulse_ms_q) else $error("pulse longer than setting");
    a_count_step: assert property ($rose(operation_pulse) && !$past(clr_count) // RULE_17
        |-> op_count_q == $past(op_count_q) + 32'h0000_0001) else $error("counter missed operation");
    a_synsw_zero: assert property (synsw_ms_q == 16'h0000 |=> !synchro_switch_trigger) // RULE_23
        else $error("synchro trigger with zero wait");
    a_event_state: assert property (status_event_valid |-> status_event_state == state_q) // RULE_19
        else $error("event state mismatch");
    a_one_command: assert property (!(open_command_pulse && close_command_pulse)) // RULE_20
        else $error("both command pulses high");

    c_open_pulse: cover property ($rose(open_command_pulse));
    c_close_pulse: cover property ($rose(close_command_pulse));
    c_synchro_trigger: cover property (synchro_switch_trigger);
    c_unintended: cover property ($rose(unintended_switching_flag));
endmodule // breaker_command_control
`default_nettype wire

// >>> test/breaker_model.sv
// Breaker model: auxiliary contacts that follow the coil commands
`timescale 1ns/1ps
`default_nettype none
module breaker_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Coil commands and test controls
    input wire logic open_cmd,
    input wire logic close_cmd,
    input wire logic [7:0] lag,
    input wire logic kick,
    // Auxiliary contacts
    output logic open_status,
    output logic closed_status
);
    // ========
    // Mechanism
    logic pos_q;
    logic [7:0] cnt_q;
    // Contacts move lag cycles into a coil drive; kick moves them unasked
    always_ff @(posedge clk) begin
        if (rst) begin
            pos_q <= 1'b0;
            cnt_q <= 8'h00;
        end else if (kick) begin
            pos_q <= !pos_q;
        end else if (open_cmd || close_cmd) begin
            cnt_q <= cnt_q + 8'h01;
            if (cnt_q == lag) begin
                pos_q <= close_cmd;
            end
        end else begin
            cnt_q <= 8'h00;
        end
    end
    assign open_status = !pos_q;
    assign closed_status = pos_q;
endmodule // breaker_model
`default_nettype wire

// >>> test/breaker_command_control_bench.sv
// Bench for the breaker command control block
`timescale 1ns/1ps
`default_nettype none
`include "breaker_defs.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_total++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module breaker_command_control_bench import breaker_pkg::*;;
    // ========
    // Signals
    logic clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, lag = 8'h05;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp, r;
    logic awready, wready, bvalid, arready, rvalid, ost, cst, opc, clc, trig, oper, unint, f_cl, f_op, ev_v;
    logic le = 1'b1, re = 1'b1, syn = 1'b1, eoff = 1'b1, eon = 1'b1, blk = 1'b0, ext = 1'b0, kick = 1'b0;
    logic c, rm, v_le, v_re, v_blk, v_eoff, v_eon, cst_q = 1'b0;
    cb_state_e ev_s, ev_last = CB_INTER;
    int err_total = 0, compares = 0, trig_n = 0, moves = 0, op_run = 0, op_last = 0, len, t0;
    always #2 clk = !clk;
    breaker_command_control #(.TICK_CYCLES(10)) dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .local_enable(le), .remote_enable(re), .synchronism_permit(syn), .open_interlock_permit(eoff),
        .close_interlock_permit(eon), .operation_block(blk), .breaker_open_status(ost),
        .breaker_closed_status(cst), .external_switching_indication(ext), .open_command_pulse(opc),
        .close_command_pulse(clc), .synchro_switch_trigger(trig), .operation_pulse(oper),
        .unintended_switching_flag(unint), .breaker_closed(f_cl), .breaker_opened(f_op),
        .status_event_valid(ev_v), .status_event_state(ev_s));
    breaker_model partner (.clk(clk), .rst(rst), .open_cmd(opc), .close_cmd(clc), .lag(lag), .kick(kick),
        .open_status(ost), .closed_status(cst));
    // Monitors sample at the falling edge, where outputs have settled
    always @(negedge clk) begin
        if (trig === 1'b1) trig_n++;
        if (ev_v === 1'b1) ev_last = ev_s;
        if (!rst && cst !== cst_q) moves++;
        cst_q = cst;
        if (oper === 1'b1) op_run++;
        else if (op_run != 0) begin
            op_last = op_run;
            op_run = 0;
        end
    end
    // ========
    // Tasks
    task automatic print_verdict;
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic tout;
        err_total++;
        $display("CHECK FAILED handshake exp done got timeout");
        print_verdict();
    endtask
    // Handshakes judged at the falling edge, where the next rising edge's values already stand
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
        int n;
        logic ha, hw, hb;
        n = 0;
        hb = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!hb) begin
            @(negedge clk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            hb = bvalid && bready;
            rs = bresp;
            @(posedge clk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
            n++;
            if (n > 100) tout();
        end
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        logic ha, hr;
        n = 0;
        hr = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!hr) begin
            @(negedge clk);
            ha = arvalid && arready;
            hr = rvalid && rready;
            if (hr) begin
                `CHK("rdata", e, rdata)
                `CHK("rresp", er, rresp)
            end
            @(posedge clk);
            if (ha) arvalid <= 1'b0;
            n++;
            if (n > 100) tout();
        end
    endtask
    task automatic cmd(input logic cl, input logic rmt, input logic ef, output int ln);
        logic hit;
        int n;
        wr(`BCC_REG_CMD, {30'h0, rmt, cl}, r);
        hit = 1'b0;
        ln = 0;
        n = 0;
        while (!hit && n < 30) begin
            @(negedge clk);
            hit = cl ? clc : opc;
            n++;
        end
        `CHK("cmd_pulse", ef, hit)
        `CHK("other_pulse", 1'b0, cl ? opc : clc)
        while (hit === 1'b1 && ln < 4000) begin
            @(negedge clk);
            hit = cl ? clc : opc;
            ln++;
        end
        if (ln >= 4000) tout();
        @(posedge clk);
    endtask
    task automatic quiet;
        logic s;
        s = 1'b0;
        repeat (30) begin
            @(negedge clk);
            s = s | opc | clc;
        end
        `CHK("dropped", 1'b0, s)
        @(posedge clk);
    endtask
    function automatic logic exp_fire(input logic cl, rmt, l, rv, b, off, on);
        logic p;
        p = rmt ? rv : l;
        p = p && !b;
        return p && (cl ? on : off);
    endfunction
    // ========
    // Sequence
    initial begin
        void'($urandom(73779));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk_rd(`BCC_REG_PULSE, 32'h12c, 2'b00);
        chk_rd(`BCC_REG_COUNT, 32'h0, 2'b00);
        chk_rd(8'h20, 32'h0, 2'b10);
        wr(`BCC_REG_SYNC, 32'd20, r);
        syn <= 1'b0;
        t0 = trig_n;
        cmd(1'b1, 1'b0, 1'b0, len);
        repeat (400) @(posedge clk);
        `CHK("trig_zero", 0, trig_n - t0)
        wr(`BCC_REG_SYNSW, 32'd5, r);
        cmd(1'b1, 1'b0, 1'b0, len);
        repeat (400) @(posedge clk);
        `CHK("trig_once", 1, trig_n - t0)
        syn <= 1'b1;
        quiet();
        cmd(1'b1, 1'b0, 1'b1, len);
        `CHK("confirm_len", 1'b1, len >= 990 && len <= 1030)
        `CHK("closed_out", 1'b1, f_cl)
        `CHK("opened_out", 1'b0, f_op)
        `CHK("event", CB_CLOSED, ev_last)
        repeat (600) @(posedge clk);
        `CHK("oper_len", 1'b1, op_last >= 1490 && op_last <= 1530)
        for (int i = 0; i < 16; i++) begin
            {c, rm, v_le, v_re, v_blk, v_eoff, v_eon} = 7'($urandom);
            if (i > 1) v_blk = v_blk && 1'($urandom);
            if (i == 0) {c, rm, v_le, v_re, v_blk, v_eoff, v_eon} = 7'b0110011;
            if (i == 1) {c, rm, v_le, v_re, v_blk, v_eoff, v_eon} = 7'b1011111;
            le <= v_le;
            re <= v_re;
            blk <= v_blk;
            eoff <= v_eoff;
            eon <= v_eon;
            lag <= 8'($urandom % 40);
            @(posedge clk);
            cmd(c, rm, exp_fire(c, rm, v_le, v_re, v_blk, v_eoff, v_eon), len);
            {le, re, blk, eoff, eon} <= 5'b11011;
            if (len == 0) quiet();
            else repeat (600) @(posedge clk);
            `CHK("event_track", cst ? CB_CLOSED : CB_OPEN, ev_last)
        end
        // Past the window in which a change still counts as commanded
        repeat (1200) @(posedge clk);
        ext <= 1'b1;
        kick <= 1'b1;
        @(posedge clk);
        kick <= 1'b0;
        repeat (5) @(posedge clk);
        ext <= 1'b0;
        `CHK("unint_ext", 1'b0, unint)
        repeat (1600) @(posedge clk);
        kick <= 1'b1;
        @(posedge clk);
        kick <= 1'b0;
        repeat (1600) @(posedge clk);
        `CHK("unint", 1'b1, unint)
        chk_rd(`BCC_REG_COUNT, 32'(moves), 2'b00);
        wr(`BCC_REG_CLEAR, 32'h3, r);
        `CHK("bresp", 2'b00, r)
        chk_rd(`BCC_REG_COUNT, 32'h0, 2'b00);
        `CHK("unint_clear", 1'b0, unint)
        print_verdict();
    end
endmodule // breaker_command_control_bench
`default_nettype wire
